/* File: logic/asym_access_pkg.sv */
// Constants, offsets and encodings for the group access state block.
// Assumes a 32-bit APB slave and single-clock command and identify paths.
package asym_access_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CAPS   = 8'h04;
	localparam logic [7:0] OFS_MAXGID = 8'h08;
	localparam logic [7:0] OFS_GRP    = 8'h0C;
	localparam logic [7:0] OFS_NSMAP  = 8'h10;
	localparam logic [7:0] OFS_ISTAT  = 8'h14;
	localparam logic [7:0] OFS_IMASK  = 8'h18;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         CTRL_NOTICE_BIT = 0;
	localparam int         CAP_OPT_BIT     = 0;
	localparam int         CAP_FIXED_BIT   = 6;
	localparam int         CAP_W           = 7;
	localparam logic [6:0] CAPS_RST        = 7'h1F;
	localparam int         GRP_STATE_LSB   = 8;
	localparam int         NSMAP_NS_LSB    = 8;
	localparam int         NSMAP_ATT_BIT   = 16;
	localparam int         EV_ENTRY        = 0;
	localparam int         EV_FAIL         = 1;
	localparam int         EV_GID          = 2;
	localparam int         EV_REFUSE       = 3;
	localparam int         EV_W            = 4;
	// ----------------------------------------------------------------
	// Access states and completion status
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_OPT    = 3'h0,
		ST_NONOPT = 3'h1,
		ST_CHANGE = 3'h3,
		ST_INACC  = 3'h2,
		ST_PLOSS  = 3'h6
	} asym_state_e;
	localparam logic [7:0] SC_SUCCESS = 8'h00;
	localparam logic [7:0] SC_BAD_NS  = 8'h0B;
	localparam logic [7:0] SC_PLOSS   = 8'h01;
	localparam logic [7:0] SC_INACC   = 8'h02;
	localparam logic [7:0] SC_TRANS   = 8'h03;
endpackage

/* File: logic/grp_tbl_if.sv */
// Carrier between the controller and its group state table.
// Assumes both ends share pclk.
`timescale 1ns/10ps
interface grp_tbl_if
	import asym_access_pkg::*;
	#(parameter int GW = 8);
	logic                 wr_en;
	logic [GW-1:0]        wr_gid;
	asym_state_e          wr_state;
	logic [CAP_W-1:0]     caps;
	logic                 entered;
	logic                 failed;
	logic [GW-1:0]        gid_a;
	logic [GW-1:0]        gid_b;
	asym_state_e          st_a;
	asym_state_e          st_b;
	modport table_end (input wr_en, wr_gid, wr_state, caps, gid_a, gid_b,
		output entered, failed, st_a, st_b);
	modport user_end (output wr_en, wr_gid, wr_state, caps, gid_a, gid_b,
		input entered, failed, st_a, st_b);
endinterface // grp_tbl_if

/* File: logic/group_state_table.sv */
// One access state register per group, with two lookup ports.
// Assumes group identifiers come from the controller over grp_tbl_if.
`timescale 1ns/10ps
module group_state_table
	import asym_access_pkg::*;
	#(
		parameter int NUM_GROUPS = 8,
		parameter int GW         = 8
	)
	(
		// Clock and reset
		input wire logic    pclk,
		input wire logic    presetn,
		// Table port
		grp_tbl_if.table_end tbl
	);
	initial if (NUM_GROUPS < 1 || NUM_GROUPS >= (1 << GW))
		$error("NUM_GROUPS out of range");

	asym_state_e state_ff [1:NUM_GROUPS];
	logic        entered_ff;
	logic        failed_ff;
	logic        wr_cap;
	asym_state_e cur_state;

	wire wr_in_range = (tbl.wr_gid != '0) && (tbl.wr_gid <= GW'(NUM_GROUPS));
	assign cur_state = wr_in_range ? state_ff[tbl.wr_gid] : ST_OPT;

	always_comb
	begin
		unique case (tbl.wr_state)
			ST_OPT:    wr_cap = tbl.caps[0];
			ST_NONOPT: wr_cap = tbl.caps[1];
			ST_INACC:  wr_cap = tbl.caps[2];
			ST_PLOSS:  wr_cap = tbl.caps[3];
			ST_CHANGE: wr_cap = tbl.caps[4];
			default:   wr_cap = 1'b0;
		endcase
	end

	wire locked = (cur_state == ST_PLOSS) && (tbl.wr_state != ST_PLOSS);
	wire do_wr  = tbl.wr_en && wr_in_range && wr_cap && !locked;

	for (genvar g = 1; g <= NUM_GROUPS; g++)
	begin : g_grp
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				state_ff[g] <= ST_OPT;
			else if (do_wr && tbl.wr_gid == GW'(g))
				state_ff[g] <= tbl.wr_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			entered_ff <= 1'b0;
			failed_ff  <= 1'b0;
		end
		else
		begin
			entered_ff <= do_wr && (tbl.wr_state != ST_CHANGE);
			failed_ff  <= tbl.wr_en && !do_wr;
		end
	end

	assign tbl.entered = entered_ff;
	assign tbl.failed  = failed_ff;
	assign tbl.st_a = (tbl.gid_a != '0 && tbl.gid_a <= GW'(NUM_GROUPS))
		? state_ff[tbl.gid_a] : ST_INACC;
	assign tbl.st_b = (tbl.gid_b != '0 && tbl.gid_b <= GW'(NUM_GROUPS))
		? state_ff[tbl.gid_b] : ST_INACC;

	AST_PLOSS_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
		tbl.wr_en && wr_in_range && cur_state == ST_PLOSS
		|=> state_ff[$past(tbl.wr_gid)] == ST_PLOSS
		&& (failed_ff || $past(tbl.wr_state) == ST_PLOSS))
		else $error("persistent loss left");
endmodule // group_state_table

/* File: logic/asym_access_ctrl.sv */
// Group access state controller: APB registers, command admission,
// identify capacity scrubbing and change notice interrupt.
// Assumes command and identify requests are synchronous to pclk.
//
// Summary of operation
// - Group members always share one access state.
// - Group id valid if nonzero, within maximum.
// - Each group identifier is unique.
// - Fixed-id capability freezes attached namespace group.
// - Group identifier change raises a notice.
// - Five states: optimized, non-optimized, inaccessible, loss, changing.
// - Optimized always reportable; others optional.
// - Optimized or non-optimized commands run normally.
// - Inaccessible group data never reached.
// - Capacity fields zero when inaccessible or lost.
// - Inaccessible group fails with inaccessible status.
// - Lost group fails with persistent loss status.
// - Persistent loss never changes state.
// - Changing group fails with transition status.
// - Notices on entry to any state but changing, and on failed transitions.
// - Exempt admin commands ignore access state.
`timescale 1ns/10ps
module asym_access_ctrl
	import asym_access_pkg::*;
	#(
		parameter int NUM_GROUPS = 8,
		parameter int NUM_NS     = 16,
		parameter int CAP_DW     = 64
	)
	(
		// Clock and reset
		input  wire logic              pclk,
		input  wire logic              presetn,
		// APB slave
		input  wire logic              psel,
		input  wire logic              penable,
		input  wire logic              pwrite,
		input  wire logic [7:0]        paddr,
		input  wire logic [31:0]       pwdata,
		output logic [31:0]            prdata,
		output logic                   pready,
		output logic                   pslverr,
		// Command admission
		input  wire logic              cmd_valid,
		input  wire logic [31:0]       cmd_namespace_identifier,
		input  wire logic              cmd_exempt,
		output logic                   resp_valid,
		output logic [7:0]             resp_status,
		// Identify capacity scrubbing
		input  wire logic              id_valid,
		input  wire logic [31:0]       id_namespace_identifier,
		input  wire logic [CAP_DW-1:0] id_namespace_utilization,
		input  wire logic [CAP_DW-1:0] id_namespace_capacity,
		output logic                   id_out_valid,
		output logic [CAP_DW-1:0]      id_namespace_utilization_out,
		output logic [CAP_DW-1:0]      id_namespace_capacity_out,
		// Interrupt
		output logic                   irq
	);
	localparam int GW  = 8;
	localparam int NSW = (NUM_NS > 1) ? $clog2(NUM_NS) : 1;
	initial if (NUM_NS < 1 || NUM_NS > 255 || (1 << NSW) != NUM_NS)
		$error("NUM_NS must be a power of two up to 128");
	initial if (NUM_GROUPS < 1 || NUM_GROUPS > 255)
		$error("NUM_GROUPS out of range");

	grp_tbl_if #(.GW(GW)) tbl ();

	group_state_table #(
		.NUM_GROUPS (NUM_GROUPS),
		.GW         (GW)
	) u_table (
		.pclk    (pclk),
		.presetn (presetn),
		.tbl     (tbl)
	);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic                 notice_en_ff;
	logic [CAP_W-1:0]     caps_ff;
	logic [GW-1:0]        grp_sel_ff;
	logic [NSW-1:0]       ns_sel_ff;
	logic [EV_W-1:0]      istat_ff;
	logic [EV_W-1:0]      imask_ff;
	logic [GW-1:0]        ns_gid_ff [NUM_NS];
	logic [NUM_NS-1:0]    ns_att_ff;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire acc      = psel && penable;
	wire wr       = acc && pwrite;
	wire hit_ctrl = paddr == OFS_CTRL;
	wire hit_caps = paddr == OFS_CAPS;
	wire hit_max  = paddr == OFS_MAXGID;
	wire hit_grp  = paddr == OFS_GRP;
	wire hit_ns   = paddr == OFS_NSMAP;
	wire hit_ist  = paddr == OFS_ISTAT;
	wire hit_imk  = paddr == OFS_IMASK;
	wire mapped   = hit_ctrl | hit_caps | hit_max | hit_grp | hit_ns | hit_ist | hit_imk;

	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	// ----------------------------------------------------------------
	// Group state writes
	// ----------------------------------------------------------------
	wire [GW-1:0] w_gid   = pwdata[GW-1:0];
	wire [2:0]    w_state = pwdata[GRP_STATE_LSB +: 3];

	assign tbl.wr_en    = wr && hit_grp;
	assign tbl.wr_gid   = w_gid;
	assign tbl.wr_state = asym_state_e'(w_state);
	assign tbl.caps     = caps_ff;
	assign tbl.gid_b    = grp_sel_ff;

	// ----------------------------------------------------------------
	// Namespace map writes
	// ----------------------------------------------------------------
	wire [7:0]     w_ns_raw = pwdata[NSMAP_NS_LSB +: 8];
	wire [NSW-1:0] w_ns     = w_ns_raw[NSW-1:0];
	wire           w_att    = pwdata[NSMAP_ATT_BIT];
	wire           ns_wr    = wr && hit_ns;
	wire           ns_in    = w_ns_raw < 8'(NUM_NS);
	wire           gid_diff = ns_gid_ff[w_ns] != w_gid;
	wire           ns_frozen = caps_ff[CAP_FIXED_BIT] && ns_att_ff[w_ns] && gid_diff;
	wire           ns_refuse = ns_wr && (!ns_in || ns_frozen);
	wire           ns_ok_wr  = ns_wr && ns_in && !ns_frozen;

	for (genvar n = 0; n < NUM_NS; n++)
	begin : g_ns
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				ns_gid_ff[n] <= '0;
				ns_att_ff[n] <= 1'b0;
			end
			else if (ns_ok_wr && w_ns == NSW'(n))
			begin
				ns_gid_ff[n] <= w_gid;
				ns_att_ff[n] <= w_att;
			end
		end
	end

	// ----------------------------------------------------------------
	// Events and interrupt
	// ----------------------------------------------------------------
	logic [EV_W-1:0] ev;
	assign ev[EV_ENTRY]  = tbl.entered && notice_en_ff;
	assign ev[EV_FAIL]   = tbl.failed && notice_en_ff;
	assign ev[EV_GID]    = ns_ok_wr && gid_diff && notice_en_ff;
	assign ev[EV_REFUSE] = ns_refuse;

	wire [EV_W-1:0] ist_clr = (wr && hit_ist) ? pwdata[EV_W-1:0] : '0;
	wire [EV_W-1:0] nxt_istat = ev | (istat_ff & ~ist_clr);
	assign irq = |(istat_ff & imask_ff);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			notice_en_ff <= 1'b0;
			caps_ff      <= CAPS_RST;
			grp_sel_ff   <= '0;
			ns_sel_ff    <= '0;
			istat_ff     <= '0;
			imask_ff     <= '0;
		end
		else
		begin
			istat_ff <= nxt_istat;
			if (wr && hit_ctrl)
				notice_en_ff <= pwdata[CTRL_NOTICE_BIT];
			if (wr && hit_caps)
				caps_ff <= pwdata[CAP_W-1:0] | CAP_W'(1 << CAP_OPT_BIT);
			if (wr && hit_grp)
				grp_sel_ff <= w_gid;
			if (ns_wr)
				ns_sel_ff <= w_ns;
			if (wr && hit_imk)
				imask_ff <= pwdata[EV_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	wire [31:0] rd_grp = {21'h0, tbl.st_b, grp_sel_ff};
	wire [31:0] rd_ns  = {15'h0, ns_att_ff[ns_sel_ff], 8'(ns_sel_ff),
		ns_gid_ff[ns_sel_ff]};
	assign prdata = !acc || pwrite ? 32'h0 :
		hit_ctrl ? 32'(notice_en_ff) :
		hit_caps ? 32'(caps_ff) :
		hit_max  ? 32'(NUM_GROUPS) :
		hit_grp  ? rd_grp :
		hit_ns   ? rd_ns :
		hit_ist  ? 32'(istat_ff) :
		hit_imk  ? 32'(imask_ff) : 32'h0;

	// ----------------------------------------------------------------
	// Command admission
	// ----------------------------------------------------------------
	wire [NSW-1:0] c_idx  = NSW'(cmd_namespace_identifier - 32'h1);
	wire           c_nsok = cmd_namespace_identifier != 32'h0 && cmd_namespace_identifier <= 32'(NUM_NS) && ns_att_ff[c_idx];
	wire [GW-1:0]  c_gid  = ns_gid_ff[c_idx];
	wire           c_gidok = c_gid != '0 && c_gid <= GW'(NUM_GROUPS);
	assign tbl.gid_a = c_gid;

	logic [7:0] c_status;
	always_comb
	begin
		c_status = SC_BAD_NS;
		if (cmd_exempt)
			c_status = SC_SUCCESS;
		else if (c_nsok && c_gidok)
		begin
			unique case (tbl.st_a)
				ST_OPT, ST_NONOPT: c_status = SC_SUCCESS;
				ST_INACC:          c_status = SC_INACC;
				ST_PLOSS:          c_status = SC_PLOSS;
				ST_CHANGE:         c_status = SC_TRANS;
				default:           c_status = SC_INACC;
			endcase
		end
	end

	logic       resp_valid_ff;
	logic [7:0] resp_status_ff;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resp_valid_ff  <= 1'b0;
			resp_status_ff <= SC_SUCCESS;
		end
		else
		begin
			resp_valid_ff  <= cmd_valid;
			resp_status_ff <= cmd_valid ? c_status : resp_status_ff;
		end
	end
	assign resp_valid  = resp_valid_ff;
	assign resp_status = resp_status_ff;

	// ----------------------------------------------------------------
	// Identify capacity scrubbing
	// ----------------------------------------------------------------
	wire [NSW-1:0] i_idx  = NSW'(id_namespace_identifier - 32'h1);
	wire           i_nsok = id_namespace_identifier != 32'h0 && id_namespace_identifier <= 32'(NUM_NS);
	wire [GW-1:0]  i_gid  = ns_gid_ff[i_idx];
	wire [GW-1:0]  i_lgid = i_nsok ? i_gid : '0;
	wire           i_gidok = i_lgid != '0 && i_lgid <= GW'(NUM_GROUPS);
	asym_state_e   i_state;

	// Shadow of group states for the identify lookup port
	asym_state_e st_shadow_ff [1:NUM_GROUPS];
	for (genvar s = 1; s <= NUM_GROUPS; s++)
	begin : g_sh
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				st_shadow_ff[s] <= ST_OPT;
			else if (grp_sel_ff == GW'(s))
				st_shadow_ff[s] <= tbl.st_b;
		end
	end

	function automatic asym_state_e tbl_lookup(input logic [GW-1:0] g);
		tbl_lookup = (g == grp_sel_ff) ? tbl.st_b : st_shadow_ff[g];
	endfunction

	assign i_state = i_gidok ? tbl_lookup(i_lgid) : ST_OPT;
	wire i_scrub = i_state == ST_INACC || i_state == ST_PLOSS;

	logic              id_v_ff;
	logic [CAP_DW-1:0] namespace_utilization_ff;
	logic [CAP_DW-1:0] ncap_ff;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			id_v_ff <= 1'b0;
			namespace_utilization_ff <= '0;
			ncap_ff <= '0;
		end
		else
		begin
			id_v_ff <= id_valid;
			if (id_valid)
			begin
				namespace_utilization_ff <= i_scrub ? '0 : id_namespace_utilization;
				ncap_ff <= i_scrub ? '0 : id_namespace_capacity;
			end
		end
	end
	assign id_out_valid  = id_v_ff;
	assign id_namespace_utilization_out   = namespace_utilization_ff;
	assign id_namespace_capacity_out = ncap_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_cmd_in(asym_state_e st);
		cmd_valid && !cmd_exempt && c_nsok && c_gidok && tbl.st_a == st;
	endsequence
	sequence s_resp(logic [7:0] sc);
		resp_valid && resp_status == sc;
	endsequence

	AST_INACC_FAIL: assert property (s_cmd_in(ST_INACC) |=> s_resp(SC_INACC))
		else $error("inaccessible command not failed");
	AST_PLOSS_FAIL: assert property (s_cmd_in(ST_PLOSS) |=> s_resp(SC_PLOSS))
		else $error("lost group command not failed");
	AST_TRANS_FAIL: assert property (s_cmd_in(ST_CHANGE) |=> s_resp(SC_TRANS))
		else $error("changing group command not failed");
	AST_ACCESS_OK: assert property ((s_cmd_in(ST_OPT) or s_cmd_in(ST_NONOPT))
		|=> s_resp(SC_SUCCESS))
		else $error("accessible command refused");
	AST_EXEMPT_OK: assert property (cmd_valid && cmd_exempt |=> s_resp(SC_SUCCESS))
		else $error("exempt command refused");
	AST_GID_ZERO: assert property (cmd_valid && !cmd_exempt && !c_gidok
		|=> s_resp(SC_BAD_NS))
		else $error("invalid group identifier admitted");
	AST_CAP_ZERO: assert property (id_valid && i_scrub
		|=> id_out_valid && id_namespace_utilization_out == '0 && id_namespace_capacity_out == '0)
		else $error("capacity not cleared");
	AST_GID_FROZEN: assert property (ns_wr && ns_in && caps_ff[CAP_FIXED_BIT]
		&& ns_att_ff[w_ns] && gid_diff |=> ns_gid_ff[$past(w_ns)] == $past(ns_gid_ff[w_ns])
		&& istat_ff[EV_REFUSE])
		else $error("fixed group identifier changed");
	AST_ENTRY_NOTICE: assert property (tbl.entered && notice_en_ff
		|=> istat_ff[EV_ENTRY])
		else $error("entry notice missing");
	AST_GID_NOTICE: assert property (ns_ok_wr && gid_diff && notice_en_ff
		|=> istat_ff[EV_GID])
		else $error("identifier change notice missing");
endmodule // asym_access_ctrl

/* File: dv/host_cmd_model.sv */
// Host side partner: issues commands and identify requests.
// Assumes callers enter its tasks just after a rising pclk edge.
`timescale 1ns/10ps
module host_cmd_model
	#(parameter int CAP_DW = 64)
	(
		// Clock
		input  wire logic              pclk,
		// Requests toward the controller
		output logic                   cmd_valid,
		output logic [31:0]            cmd_namespace_identifier,
		output logic                   cmd_exempt,
		output logic                   id_valid,
		output logic [31:0]            id_namespace_identifier,
		output logic [CAP_DW-1:0]      id_namespace_utilization,
		output logic [CAP_DW-1:0]      id_namespace_capacity
	);
	initial
	begin
		cmd_valid  = 1'b0;
		cmd_namespace_identifier   = 32'h0;
		cmd_exempt = 1'b0;
		id_valid   = 1'b0;
		id_namespace_identifier    = 32'h0;
		id_namespace_utilization    = '0;
		id_namespace_capacity  = '0;
	end
	// retries go out as fresh commands
	task automatic send(input logic [31:0] n, input logic ex, input logic last);
		cmd_valid  <= 1'b1;
		cmd_namespace_identifier   <= n;
		cmd_exempt <= ex;
		@(posedge pclk);
		if (last)
		begin
			cmd_valid  <= 1'b0;
			cmd_namespace_identifier   <= ~n;
			cmd_exempt <= ~ex;
			@(posedge pclk);
		end
	endtask
	task automatic ident(input logic [31:0] n, input logic [CAP_DW-1:0] nu, nc);
		id_valid  <= 1'b1;
		id_namespace_identifier   <= n;
		id_namespace_utilization   <= nu;
		id_namespace_capacity <= nc;
		@(posedge pclk);
		id_valid  <= 1'b0;
		id_namespace_identifier   <= ~n;
		id_namespace_utilization   <= ~nu;
		id_namespace_capacity <= ~nc;
		@(posedge pclk);
	endtask
endmodule // host_cmd_model

/* File: dv/namespace_group_access_state_tb.sv */
// Self-checking bench for the group access state controller.
// Assumes the host model sits on the command and identify ports.
`timescale 1ns/10ps
module namespace_group_access_state_tb;
	import asym_access_pkg::*;
	localparam int CW = 64;
	logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]           paddr, resp_status;
	logic [31:0]          pwdata, prdata, cmd_namespace_identifier, id_namespace_identifier;
	logic                 cmd_valid, cmd_exempt, resp_valid, id_valid, id_out_valid, irq;
	logic [CW-1:0]        id_namespace_utilization, id_namespace_capacity, namespace_utilization_o, cap_o, nu, nc;
	int                   n_mismatch, tests_run;
	logic [7:0]           q_st[$];
	logic [2*CW-1:0]      q_id[$];
	logic [64:0]          q_rd[$];
	logic [64:0]          r;
	asym_state_e          sts[4];
	logic [7:0]           exs[4];

	asym_access_ctrl #(.NUM_GROUPS(8), .NUM_NS(16), .CAP_DW(CW)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_namespace_identifier(cmd_namespace_identifier),
		.cmd_exempt(cmd_exempt), .resp_valid(resp_valid), .resp_status(resp_status),
		.id_valid(id_valid), .id_namespace_identifier(id_namespace_identifier), .id_namespace_utilization(id_namespace_utilization), .id_namespace_capacity(id_namespace_capacity),
		.id_out_valid(id_out_valid), .id_namespace_utilization_out(namespace_utilization_o), .id_namespace_capacity_out(cap_o),
		.irq(irq));
	host_cmd_model #(.CAP_DW(CW)) host (.pclk(pclk), .cmd_valid(cmd_valid),
		.cmd_namespace_identifier(cmd_namespace_identifier), .cmd_exempt(cmd_exempt), .id_valid(id_valid),
		.id_namespace_identifier(id_namespace_identifier), .id_namespace_utilization(id_namespace_utilization), .id_namespace_capacity(id_namespace_capacity));

	// ----------------------------------------------------------------
	// Compare and report
	// ----------------------------------------------------------------
	task automatic cmp(input logic [2*CW-1:0] got, input logic [2*CW-1:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	task automatic chk_status(input logic [7:0] g, input logic [7:0] e);
		cmp(g, e);
	endtask
	task automatic chk_ident(input logic [2*CW-1:0] g, input logic [2*CW-1:0] e);
		cmp(g, e);
	endtask
	task automatic chk_read(input logic [32:0] g, input logic [32:0] e);
		cmp(g, e);
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Result monitor
	// ----------------------------------------------------------------
	always @(posedge pclk)
	begin
		if (resp_valid === 1'b1)
			chk_status(resp_status, q_st.size() ? q_st.pop_front() : 'x);
		if (id_out_valid === 1'b1)
			chk_ident({namespace_utilization_o, cap_o}, q_id.size() ? q_id.pop_front() : 'x);
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			r = q_rd.size() ? q_rd.pop_front() : 'x;
			chk_read({pslverr, prdata & r[63:32]}, {r[64], r[31:0] & r[63:32]});
		end
	end

	// ----------------------------------------------------------------
	// Stimulus tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
			n_mismatch++;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic err);
		q_rd.push_back({err, m, e});
		apb(a, 1'b0, 32'h0);
	endtask
	task automatic grp(input logic [7:0] g, input asym_state_e s);
		apb(OFS_GRP, 1'b1, {21'h0, s, g});
	endtask
	task automatic nsmap(input logic [7:0] idx, input logic [7:0] g);
		apb(OFS_NSMAP, 1'b1, {15'h0, 1'b1, idx, g});
	endtask
	task automatic cmd(input logic [31:0] n, input logic ex, input logic [7:0] e);
		q_st.push_back(e);
		host.send(n, ex, 1'b1);
	endtask
	task automatic idn(input logic [31:0] n, input logic zero);
		nu = {$urandom, $urandom};
		nc = {$urandom, $urandom};
		q_id.push_back(zero ? '0 : {nu, nc});
		host.ident(n, nu, nc);
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial
	begin
		#(8 * 20000);
		n_mismatch++;
		final_report();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_mismatch = 0;
		tests_run = 0;
		sts = '{ST_NONOPT, ST_INACC, ST_CHANGE, ST_OPT};
		exs = '{SC_SUCCESS, SC_INACC, SC_TRANS, SC_SUCCESS};
		void'($urandom(32'h9CD7576C));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_CAPS, 32'h1F, 32'hFFFFFFFF, 1'b0);
		rd(OFS_MAXGID, 32'h8, 32'hFFFFFFFF, 1'b0);
		rd(OFS_ISTAT, 32'h0, 32'hFFFFFFFF, 1'b0);
		rd(8'h1C, 32'h0, 32'hFFFFFFFF, 1'b1);
		cmd(32'h1, 1'b0, SC_BAD_NS);
		apb(OFS_CTRL, 1'b1, 32'h1);
		apb(OFS_IMASK, 1'b1, 32'hF);
		nsmap(8'h0, 8'h1);
		nsmap(8'h1, 8'h1);
		nsmap(8'h2, 8'h2);
		nsmap(8'h3, 8'h3);
		for (int i = 0; i < 4; i++)
		begin
			apb(OFS_ISTAT, 1'b1, 32'hF);
			grp(8'h1, sts[i]);
			q_st.push_back(exs[i]);
			host.send(32'h1, 1'b0, 1'b0);
			cmd(32'h2, 1'b0, exs[i]);
			cmd(32'h1, 1'b1, SC_SUCCESS);
			idn(32'h2, sts[i] == ST_INACC);
			rd(OFS_GRP, {21'h0, sts[i], 8'h1}, 32'h7FF, 1'b0);
			rd(OFS_ISTAT, {31'h0, sts[i] != ST_CHANGE}, 32'h1, 1'b0);
			cmp(irq, sts[i] != ST_CHANGE);
		end
		for (int g = 0; g < 10; g += 9)
		begin
			apb(OFS_ISTAT, 1'b1, 32'hF);
			grp(g[7:0], ST_OPT);
			rd(OFS_ISTAT, 32'h2, 32'h2, 1'b0);
		end
		grp(8'h2, ST_PLOSS);
		cmd(32'h3, 1'b0, SC_PLOSS);
		idn(32'h3, 1'b1);
		apb(OFS_ISTAT, 1'b1, 32'hF);
		grp(8'h2, ST_OPT);
		rd(OFS_ISTAT, 32'h2, 32'h2, 1'b0);
		cmd(32'h3, 1'b0, SC_PLOSS);
		grp(8'h3, ST_INACC);
		cmd(32'h4, 1'b0, SC_INACC);
		apb(OFS_ISTAT, 1'b1, 32'hF);
		nsmap(8'h3, 8'h1);
		rd(OFS_ISTAT, 32'h4, 32'h4, 1'b0);
		cmd(32'h4, 1'b0, SC_SUCCESS);
		apb(OFS_CAPS, 1'b1, 32'h5F);
		nsmap(8'h3, 8'h3);
		rd(OFS_ISTAT, 32'h8, 32'h8, 1'b0);
		cmd(32'h4, 1'b0, SC_SUCCESS);
		cmd(32'h0, 1'b0, SC_BAD_NS);
		cmd(32'h11, 1'b0, SC_BAD_NS);
		repeat (6)
			cmd(32'h1 + ($urandom % 2), $urandom % 2, SC_SUCCESS);
		apb(OFS_IMASK, 1'b1, 32'h0);
		cmp(irq, 1'b0);
		apb(OFS_IMASK, 1'b1, 32'h8);
		cmp(irq, 1'b1);
		apb(OFS_ISTAT, 1'b1, 32'hF);
		cmp(irq, 1'b0);
		repeat (3) @(posedge pclk);
		if (q_st.size() + q_id.size() + q_rd.size() != 0)
			n_mismatch++;
		final_report();
	end
endmodule // namespace_group_access_state_tb
